/* include/vef_pkg.sv */
// constants, field layout and carrier types of the video error flag collector
package vef_pkg;

	localparam int VEF_ADDR_W = 8;
	localparam int VEF_DATA_W = 16;
	localparam int VEF_FLAG_W = 7;

	// register offsets
	localparam logic [VEF_ADDR_W-1:0] VEF_ERROR_FLAGS_ADDR = 8'h01;
	localparam logic [VEF_ADDR_W-1:0] VEF_ERROR_DETECT_MASK_ADDR = 8'h25;
	localparam logic [VEF_ADDR_W-1:0] VEF_IRQ_STATUS_ADDR = 8'h26;
	localparam logic [VEF_ADDR_W-1:0] VEF_IRQ_ENABLE_ADDR = 8'h27;
	localparam logic [VEF_ADDR_W-1:0] VEF_CONTROL_ADDR = 8'h28;

	// bit positions in the flag, mask and irq registers
	localparam int VEF_END_ACTIVE_VIDEO_BIT = 0;
	localparam int VEF_START_ACTIVE_VIDEO_BIT = 1;
	localparam int VEF_CHECKSUM_BIT = 2;
	localparam int VEF_LOCK_BIT = 3;
	localparam int VEF_ACTIVE_PICTURE_CRC_BIT = 4;
	localparam int VEF_FULL_FIELD_CRC_BIT = 5;
	localparam int VEF_STANDARD_MISMATCH_BIT = 6;

	// control register fields
	localparam int VEF_CTRL_MODE_LSB = 0;
	localparam int VEF_CTRL_MANUAL_BIT = 2;

	// reset values
	localparam logic [VEF_FLAG_W-1:0] VEF_FLAGS_RESET = 7'h00;
	localparam logic [VEF_FLAG_W-1:0] VEF_MASK_RESET = 7'h00;
	localparam logic [VEF_DATA_W-1:0] VEF_RDATA_RESET = 16'h0000;
	localparam logic VEF_LOCKED_RESET = 1'b0;
	localparam logic VEF_BYPASS_N_RESET = 1'b1;
	localparam logic VEF_MANUAL_RESET = 1'b0;

	typedef enum logic [1:0] {
		VEF_MODE_SMPTE = 2'b00,
		VEF_MODE_DVB_ASI = 2'b01,
		VEF_MODE_DATA_THROUGH = 2'b10
	} vef_mode_e;

	// register access from the host port
	typedef struct packed {
		logic [VEF_ADDR_W-1:0] addr;
		logic [VEF_DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} vef_bus_s;

	// one-cycle error and flag clear events from the video path logic
	typedef struct packed {
		logic end_active_video;
		logic start_active_video;
		logic checksum;
		logic active_picture_crc;
		logic full_field_crc;
		logic pid_v0_mismatch;
		logic pid_v1_mismatch;
		logic field_start;
		logic standard_change;
	} vef_evt_s;

endpackage

/* src/vef_collector.sv */
// error flag collection, masking, summary pin and host registers of the video receiver
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
`default_nettype none

module vef_collector
	import vef_pkg::*;
#(
	parameter int ADDR_W = vef_pkg::VEF_ADDR_W,
	parameter int DATA_W = vef_pkg::VEF_DATA_W
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire vef_pkg::vef_bus_s bus_in,
	output logic [vef_pkg::VEF_DATA_W-1:0] rdata_out,
	input wire vef_pkg::vef_evt_s evt_in,
	input wire logic locked_in,
	input wire logic video_processing_bypass_n_in,
	output logic data_error_n_out,
	output logic irq_out
);
	import vef_pkg::*;

	// the register map and field layout are fixed by the package
	if (ADDR_W != VEF_ADDR_W || DATA_W != VEF_DATA_W) begin : g_bad_width
		$error("vef_collector: address and data widths must match the package");
	end

	// widen a flag vector onto the data bus, unused upper bits read zero
	function automatic logic [VEF_DATA_W-1:0] to_word(input logic [VEF_FLAG_W-1:0] v);
		to_word = {{(VEF_DATA_W-VEF_FLAG_W){1'b0}}, v};
	endfunction

	// register access decode, used by the write decodes and the flag read clear
	function automatic logic hit(input vef_bus_s b, input logic [VEF_ADDR_W-1:0] a);
		hit = (b.addr == a);
	endfunction

	logic locked_s1, locked_s2, locked_s3, locked_stable;
	logic bypass_s1, bypass_s2, bypass_s3, bypass_n_stable;
	logic [VEF_FLAG_W-1:0] error_flags;
	logic [VEF_FLAG_W-1:0] error_detect_mask;
	logic [VEF_FLAG_W-1:0] irq_status;
	logic [VEF_FLAG_W-1:0] irq_enable;
	vef_mode_e mode;
	logic manual_mode;
	logic [VEF_FLAG_W-1:0] next_error_flags;
	logic [VEF_FLAG_W-1:0] raw_events;
	logic [VEF_FLAG_W-1:0] set_events;
	logic [VEF_FLAG_W-1:0] next_irq_status;
	logic smpte_active;
	logic event_clear;
	logic level_clear;
	logic read_flags;
	vef_mode_e wr_mode;

	// pin synchronisers; a change counts once the second and third stages agree
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			locked_s1 <= VEF_LOCKED_RESET;
			locked_s2 <= VEF_LOCKED_RESET;
			locked_s3 <= VEF_LOCKED_RESET;
			locked_stable <= VEF_LOCKED_RESET;
			bypass_s1 <= VEF_BYPASS_N_RESET;
			bypass_s2 <= VEF_BYPASS_N_RESET;
			bypass_s3 <= VEF_BYPASS_N_RESET;
			bypass_n_stable <= VEF_BYPASS_N_RESET;
		end else if (ce_in) begin
			locked_s1 <= locked_in;
			locked_s2 <= locked_s1;
			locked_s3 <= locked_s2;
			bypass_s1 <= video_processing_bypass_n_in;
			bypass_s2 <= bypass_s1;
			bypass_s3 <= bypass_s2;
			if (locked_s2 == locked_s3) begin
				locked_stable <= locked_s3;
			end
			if (bypass_s2 == bypass_s3) begin
				bypass_n_stable <= bypass_s3;
			end
		end
	end

	// detection of video errors runs only while processing SMPTE video
	assign smpte_active = (mode == VEF_MODE_SMPTE) && locked_stable;

	// gather the raw error events into the flag layout
	always_comb begin
		raw_events = VEF_FLAGS_RESET;
		raw_events[VEF_END_ACTIVE_VIDEO_BIT] = evt_in.end_active_video;
		raw_events[VEF_START_ACTIVE_VIDEO_BIT] = evt_in.start_active_video;
		raw_events[VEF_CHECKSUM_BIT] = evt_in.checksum;
		raw_events[VEF_ACTIVE_PICTURE_CRC_BIT] = evt_in.active_picture_crc;
		raw_events[VEF_FULL_FIELD_CRC_BIT] = evt_in.full_field_crc;
		// either payload identifier version may flag the mismatch
		raw_events[VEF_STANDARD_MISMATCH_BIT] =
			evt_in.pid_v0_mismatch | evt_in.pid_v1_mismatch;
		// lock is a level, not an event, and is checked in every mode
		raw_events[VEF_LOCK_BIT] = 1'b0;
	end

	// a mask bit high stops that error from ever being flagged
	assign set_events = smpte_active ? (raw_events & ~error_detect_mask) : VEF_FLAGS_RESET;

	assign read_flags = bus_in.rd && hit(bus_in, VEF_ERROR_FLAGS_ADDR);
	assign event_clear = read_flags || evt_in.field_start || evt_in.standard_change;
	// level clears hold every flag but lock down and win over any event in the same cycle
	assign level_clear = !locked_stable || (manual_mode && !bypass_n_stable);

	// next flag value: a new event outranks the read or field clear
	always_comb begin
		next_error_flags = error_flags;
		if (event_clear) begin
			next_error_flags = VEF_FLAGS_RESET;
		end
		next_error_flags = next_error_flags | set_events;
		if (level_clear) begin
			next_error_flags = VEF_FLAGS_RESET;
		end
		next_error_flags[VEF_LOCK_BIT] =
			!locked_stable && !error_detect_mask[VEF_LOCK_BIT];
	end

	// error status register; reset drops every bit including lock
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			error_flags <= VEF_FLAGS_RESET;
		end else if (ce_in) begin
			error_flags <= next_error_flags;
		end
	end

	// summary pin taken from the next flags so it lines up with the register
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			data_error_n_out <= 1'b1;
		end else if (ce_in) begin
			data_error_n_out <= ~(|next_error_flags);
		end
	end

	// mask register, host writable
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			error_detect_mask <= VEF_MASK_RESET;
		end else if (ce_in && bus_in.wr && hit(bus_in, VEF_ERROR_DETECT_MASK_ADDR)) begin
			error_detect_mask <= bus_in.wdata[VEF_FLAG_W-1:0];
		end
	end

	// mode and manual select; an unknown mode code is kept as data-through
	always_comb begin
		case (bus_in.wdata[VEF_CTRL_MODE_LSB +: $bits(vef_mode_e)])
			VEF_MODE_SMPTE: wr_mode = VEF_MODE_SMPTE;
			VEF_MODE_DVB_ASI: wr_mode = VEF_MODE_DVB_ASI;
			default: wr_mode = VEF_MODE_DATA_THROUGH;
		endcase
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			mode <= VEF_MODE_SMPTE;
			manual_mode <= VEF_MANUAL_RESET;
		end else if (ce_in && bus_in.wr && hit(bus_in, VEF_CONTROL_ADDR)) begin
			mode <= wr_mode;
			manual_mode <= bus_in.wdata[VEF_CTRL_MANUAL_BIT];
		end
	end

	// interrupt status: rising flags set sticky bits, a written one clears
	always_comb begin
		next_irq_status = irq_status;
		if (bus_in.wr && hit(bus_in, VEF_IRQ_STATUS_ADDR)) begin
			next_irq_status = irq_status & ~bus_in.wdata[VEF_FLAG_W-1:0];
		end
		// set after clear so a coincident event is kept
		next_irq_status = next_irq_status | (next_error_flags & ~error_flags);
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			irq_status <= VEF_FLAGS_RESET;
		end else if (ce_in) begin
			irq_status <= next_irq_status;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			irq_enable <= VEF_MASK_RESET;
		end else if (ce_in && bus_in.wr && hit(bus_in, VEF_IRQ_ENABLE_ADDR)) begin
			irq_enable <= bus_in.wdata[VEF_FLAG_W-1:0];
		end
	end

	// level interrupt, registered from the next status
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			irq_out <= 1'b0;
		end else if (ce_in) begin
			irq_out <= |(next_irq_status & irq_enable);
		end
	end

	// read data valid the cycle after the strobe, zero otherwise
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_out <= VEF_RDATA_RESET;
		end else if (ce_in) begin
			rdata_out <= VEF_RDATA_RESET;
			if (bus_in.rd) begin
				case (bus_in.addr)
					VEF_ERROR_FLAGS_ADDR: rdata_out <= to_word(error_flags);
					VEF_ERROR_DETECT_MASK_ADDR: rdata_out <= to_word(error_detect_mask);
					VEF_IRQ_STATUS_ADDR: rdata_out <= to_word(irq_status);
					VEF_IRQ_ENABLE_ADDR: rdata_out <= to_word(irq_enable);
					VEF_CONTROL_ADDR: rdata_out <= {{(VEF_DATA_W-$bits(vef_mode_e)-1){1'b0}},
						manual_mode, mode};
					default: rdata_out <= VEF_RDATA_RESET;
				endcase
			end
		end
	end

endmodule

`default_nettype wire

/* dv/vef_collector_sva.sv */
// port checker for the video error flag collector
`timescale 1ns/1ns
`default_nettype none
module vef_collector_chk
	import vef_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire vef_pkg::vef_bus_s bus_in,
	input wire logic [vef_pkg::VEF_DATA_W-1:0] rdata_out,
	input wire vef_pkg::vef_evt_s evt_in,
	input wire logic locked_in,
	input wire logic video_processing_bypass_n_in,
	input wire logic data_error_n_out,
	input wire logic irq_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// one host read strobe, and a cycle with no error events
	sequence rd_at(a);
		bus_in.rd && bus_in.addr == a;
	endsequence
	sequence quiet;
		evt_in[8:2] == 7'h00;
	endsequence
	rd_window_a: assert property (rdata_out != 0 |-> $past(bus_in.rd))
		else $error("read data outside its slot");
	upper_zero_a: assert property (rdata_out[15:7] == 9'h000)
		else $error("unused status bits read back set");
	reset_idle_a: assert property (disable iff (1'b0) rst_in |-> data_error_n_out && !irq_out
		&& rdata_out == 0) else $error("outputs not idle in reset");
	read_clear_a: assert property ((rd_at(8'h01) and quiet) ##1 rd_at(8'h01)
		|=> (rdata_out & 16'h0077) == 0) else $error("read did not clear flags");
	field_clear_a: assert property (((evt_in.field_start || evt_in.standard_change)
		and quiet) ##1 rd_at(8'h01) |=> (rdata_out & 16'h0077) == 0) else $error("no clear");
	summary_pin_a: assert property (rd_at(8'h01)
		|=> (rdata_out[6:0] != 0) == !$past(data_error_n_out)) else $error("summary pin wrong");
	unmapped_read_a: assert property (bus_in.rd && !(bus_in.addr inside {8'h01, 8'h25,
		8'h26, 8'h27, 8'h28}) |=> rdata_out == 0) else $error("unmapped read not zero");
	mask_back_a: assert property (bus_in.wr && bus_in.addr == 8'h25 ##1 rd_at(8'h25)
		|=> rdata_out == {9'h000, $past(bus_in.wdata[6:0], 2)}) else $error("mask readback");
endmodule
bind vef_collector vef_collector_chk chk (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
	.bus_in(bus_in), .rdata_out(rdata_out), .evt_in(evt_in), .locked_in(locked_in),
	.video_processing_bypass_n_in(video_processing_bypass_n_in),
	.data_error_n_out(data_error_n_out), .irq_out(irq_out));
`default_nettype wire

/* dv/vef_host.sv */
// host model driving the collector register port
`timescale 1ns/1ns
`default_nettype none
module vef_host
	import vef_pkg::*;
(
	input wire logic clk_in,
	output var vef_pkg::vef_bus_s bus_out
);
	initial bus_out = '0;
	// strobe stays up one edge; a later access may follow with no gap
	task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
		bus_out <= '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge clk_in);
	endtask
	task automatic idle();
		bus_out <= '0;
		@(posedge clk_in);
	endtask
endmodule
`default_nettype wire

/* dv/test_vef_collector.sv */
// self-checking bench for the video error flag collector
`timescale 1ns/1ns
`default_nettype none
module test_vef_collector;
	import vef_pkg::*;
	logic clk_in = 0, rst_in = 0, locked_in = 1, byp_n = 1, de_n, irq, rd_q = 0, ce = 1;
	vef_bus_s bus;
	vef_evt_s evt = '0;
	logic [15:0] rdata_out;
	logic [15:0] exp_q[$];
	logic [6:0] m;
	int miscompares = 0, tests_run = 0;
	int fb[7] = '{0, 1, 2, 4, 5, 6, 6};
	vef_collector DUT (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .bus_in(bus),
		.rdata_out(rdata_out), .evt_in(evt), .locked_in(locked_in),
		.video_processing_bypass_n_in(byp_n), .data_error_n_out(de_n), .irq_out(irq));
	vef_host host (.clk_in(clk_in), .bus_out(bus));
	initial forever #4 clk_in = ~clk_in;
	task automatic check(input string n, input logic [15:0] got, input logic [15:0] want);
		tests_run++;
		if (got !== want) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", n, want, got);
		end
	endtask
	// read data land one cycle after the strobe
	always @(posedge clk_in) begin
		if (rd_q)
			check("rdata", rdata_out, exp_q.pop_front());
		rd_q <= bus.rd;
	end
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		host.acc(1'b0, a, 16'h0000);
	endtask
	task automatic pulse(input logic [8:0] e);
		evt <= e;
		host.idle();
		evt <= '0;
		host.idle();
	endtask
	task automatic nap(input int n);
		repeat (n) host.idle();
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (1000) @(posedge clk_in);
		miscompares++;
		give_verdict();
	end
	initial begin
		void'($urandom(90498));
		rst_in <= 1;
		repeat (2) @(posedge clk_in);
		rst_in <= 0;
		nap(8);
		check("pin", {15'h0, de_n}, 16'h0001);
		rd(8'h01, 16'h0000);
		rd(8'h25, 16'h0000);
		rd(8'h30, 16'h0000);
		host.acc(1'b1, 8'h01, 16'h007F);
		rd(8'h01, 16'h0000);
		// every error event lands on its flag bit, the two identifier versions share bit 6, the next read clears it
		for (int i = 0; i < 7; i++) begin
			pulse(9'h100 >> i);
			rd(8'h01, 16'h0001 << fb[i]);
			check("pin", {15'h0, de_n}, 16'h0000);
			rd(8'h01, 16'h0000);
		end
		m = 7'($urandom()) & 7'h77;
		host.acc(1'b1, 8'h25, {9'h000, m});
		rd(8'h25, {9'h000, m});
		pulse(9'h1FC);
		rd(8'h01, {9'h000, ~m & 7'h77});
		host.acc(1'b1, 8'h25, 16'h0000);
		// unlock clears events and holds the lock bit
		pulse(9'h040);
		locked_in <= 0;
		nap(6);
		rd(8'h01, 16'h0008);
		pulse(9'h040);
		locked_in <= 1;
		nap(6);
		rd(8'h01, 16'h0000);
		for (int i = 0; i < 2; i++) begin
			pulse(9'h040);
			evt <= 9'h001 << i;
			host.idle();
			evt <= '0;
			rd(8'h01, 16'h0000);
		end
		host.acc(1'b1, 8'h28, 16'h0004);
		pulse(9'h040);
		byp_n <= 0;
		nap(6);
		rd(8'h01, 16'h0000);
		byp_n <= 1;
		// other modes drop the error events
		for (int i = 1; i < 3; i++) begin
			host.acc(1'b1, 8'h28, 16'(i));
			pulse(9'h040);
			rd(8'h01, 16'h0000);
		end
		host.acc(1'b1, 8'h28, 16'h0000);
		evt <= 9'h040;
		rd(8'h01, 16'h0000);
		evt <= '0;
		rd(8'h01, 16'h0004);
		host.acc(1'b1, 8'h26, 16'h007F);
		host.acc(1'b1, 8'h27, 16'h0004);
		pulse(9'h040);
		check("irq", {15'h0, irq}, 16'h0001);
		host.acc(1'b1, 8'h27, 16'h0000);
		nap(2);
		check("irq", {15'h0, irq}, 16'h0000);
		rd(8'h26, 16'h0004);
		host.acc(1'b1, 8'h26, 16'h0004);
		rd(8'h26, 16'h0000);
		// clock enable low freezes the flags, so a pulse then is lost
		rd(8'h01, 16'h0004);
		nap(1);
		ce <= 0;
		pulse(9'h040);
		ce <= 1;
		rd(8'h01, 16'h0000);
		host.acc(1'b1, 8'h25, 16'h007F);
		rst_in <= 1;
		nap(2);
		rst_in <= 0;
		nap(8);
		rd(8'h25, 16'h0000);
		rd(8'h01, 16'h0000);
		nap(2);
		give_verdict();
	end
endmodule
`default_nettype wire
